// ==== design/nbwp_pkg.sv ====
package nbwp_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] NBWP_OFS_GUARD  = 4'h0;
  localparam logic [3:0] NBWP_OFS_PFLASH = 4'h1;
  localparam logic [3:0] NBWP_OFS_STATUS = 4'h2;
  localparam logic [3:0] NBWP_OFS_MASK   = 4'h3;
  localparam logic [3:0] NBWP_OFS_ERRCFG = 4'h4;

  // Guard register field positions
  localparam int NBWP_BIT_OPEN = 7;
  localparam int NBWP_BIT_DIS  = 3;
  localparam logic [7:0] NBWP_RNV_MASK  = 8'h70;
  localparam logic [7:0] NBWP_DBE_VALUE = 8'h7F;

  // Protected range end and granule
  localparam logic [22:0] NBWP_RANGE_END = 23'h13FFFF;
  localparam logic [22:0] NBWP_GRANULE   = 23'h000040;

  // Status bit positions
  localparam int NBWP_ST_VIOL = 0;
  localparam int NBWP_ST_REJ  = 1;

  // Error configuration: violation interrupt enable position
  localparam int NBWP_BIT_VIOL_IE = 4;

  // Reset scenario lets any first setting through
  localparam logic [2:0] NBWP_SCEN_RST = 3'h7;

  // Scenario transition table: bit t of row f is 1 when f -> t is allowed
  localparam logic [7:0] NBWP_ALLOW [8] = '{
    8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};

  // Buffer write request from a bus master
  typedef struct packed {
    logic        valid;
    logic [22:0] addr;
    logic        in_eee;
    logic [7:0]  data;
  } nbwp_wreq_t;

  // Reset-time load of the guard byte
  typedef struct packed {
    logic       valid;
    logic       dbe;
    logic [7:0] byte_val;
  } nbwp_nvload_t;

endpackage

// ==== design/nbwp_guard.sv ====
// Operation
// - Scenarios 1,2,3 only add protection
// - Scenarios 4-7 transition per allowed table
// - Disallowed scenario write ignored, current shown
// - Reserved bits 6..4 read only
// - Open and disable bits only clear
// - Size code writable only while disabled
// - Open bit clear blocks whole partition
// - Disable bit clear enforces protected range
// - Range ends 0x13FFFF, 64*(code+1) bytes
// - Guard byte loaded from nonvolatile at reset
// - Double-bit error leaves partition fully protected
// - Protected write rejected, violation flag set
// - User partition writes never blocked
// - Flag with enable requests interrupt
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module nbwp_guard
  import nbwp_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  // Reset-time nonvolatile load
  input  wire nbwp_pkg::nbwp_nvload_t nv_load,
  // Buffer RAM write path
  input  wire nbwp_pkg::nbwp_wreq_t wreq,
  output logic                      wr_grant,
  // Register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  // Interrupt and protection view
  output logic                      irq,
  output logic [2:0]                pflash_scenario
);
  import nbwp_pkg::*;

  logic [7:0]  guard_q;
  logic [2:0]  scen_q;
  logic [1:0]  status_q;
  logic [1:0]  mask_q;
  logic        viol_ie_q;
  logic [7:0]  rdata_q;
  logic [22:0] range_lo;
  logic        in_range;
  logic        blocked;
  logic        reject_scen;
  logic        wr_guard;
  logic        wr_scen;
  logic [22:0] chk_lo;
  logic        chk_live;

  ////////////////////////////////////////////////////////////////////////////
  // Write protection check

  // Low bound is end minus size plus one
  // range size
  assign range_lo = NBWP_RANGE_END - (NBWP_GRANULE * {20'h00000, guard_q[2:0]})
                    - NBWP_GRANULE + 23'h000001;
  assign in_range = (wreq.addr >= range_lo) && (wreq.addr <= NBWP_RANGE_END);

  // combinational check, gates the RAM strobe this cycle
  // open bit clear blocks all; range applies when disable clear
  assign blocked = wreq.valid && wreq.in_eee &&
                   (!guard_q[NBWP_BIT_OPEN] || (!guard_q[NBWP_BIT_DIS] && in_range));
  assign wr_grant = wreq.valid && !blocked;

  ////////////////////////////////////////////////////////////////////////////
  // Guard register

  assign wr_guard = reg_wr && (reg_addr == NBWP_OFS_GUARD);

  // Reset value is fully protected until the nonvolatile byte lands
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      guard_q <= NBWP_DBE_VALUE;
    end else if (nv_load.valid) begin
      // load from nonvolatile byte; double-bit error forces protection
      guard_q <= nv_load.dbe ? NBWP_DBE_VALUE : nv_load.byte_val;
    end else if (wr_guard) begin
      guard_q[NBWP_BIT_OPEN] <= guard_q[NBWP_BIT_OPEN] & reg_wdata[NBWP_BIT_OPEN];
      guard_q[NBWP_BIT_DIS]  <= guard_q[NBWP_BIT_DIS] & reg_wdata[NBWP_BIT_DIS];
      // size locked once disable has cleared
      if (guard_q[NBWP_BIT_DIS]) begin
        guard_q[2:0] <= reg_wdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program flash scenario register

  assign wr_scen = reg_wr && (reg_addr == NBWP_OFS_PFLASH);
  // table lookup; same table; code from low field
  assign reject_scen = wr_scen && !NBWP_ALLOW[scen_q][reg_wdata[2:0]];

  // Starts at scenario 7 so any first setting is reachable
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      scen_q <= NBWP_SCEN_RST;
    end else if (wr_scen && !reject_scen) begin
      scen_q <= reg_wdata[2:0];
    end
  end
  assign pflash_scenario = scen_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status, mask and enable

  // Set wins over write-one-to-clear
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_q <= 2'h0;
    end else begin
      status_q[NBWP_ST_VIOL] <= blocked ||
        (status_q[NBWP_ST_VIOL] &&
         !(reg_wr && reg_addr == NBWP_OFS_STATUS && reg_wdata[NBWP_ST_VIOL]));
      status_q[NBWP_ST_REJ] <= reject_scen ||
        (status_q[NBWP_ST_REJ] &&
         !(reg_wr && reg_addr == NBWP_OFS_STATUS && reg_wdata[NBWP_ST_REJ]));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mask_q <= 2'h0;
    end else if (reg_wr && reg_addr == NBWP_OFS_MASK) begin
      mask_q <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      viol_ie_q <= 1'b0;
    end else if (reg_wr && reg_addr == NBWP_OFS_ERRCFG) begin
      viol_ie_q <= reg_wdata[NBWP_BIT_VIOL_IE];
    end
  end

  // violation with enable or its mask bit, or reject with its mask bit
  assign irq = (status_q[NBWP_ST_VIOL] && (viol_ie_q || mask_q[NBWP_ST_VIOL])) ||
               (status_q[NBWP_ST_REJ] && mask_q[NBWP_ST_REJ]);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        NBWP_OFS_GUARD:  rdata_q <= guard_q;
        NBWP_OFS_PFLASH: rdata_q <= {5'h00, scen_q};
        NBWP_OFS_STATUS: rdata_q <= {6'h00, status_q};
        NBWP_OFS_MASK:   rdata_q <= {6'h00, mask_q};
        NBWP_OFS_ERRCFG: rdata_q <= {3'h0, viol_ie_q, 4'h0};
        default:         rdata_q <= 8'h00; // Unmapped reads zero
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Checks restate the range as end minus (code*64 + 63), not the design's sum
  assign chk_lo   = NBWP_RANGE_END - {14'h0000, guard_q[2:0], 6'h3F};
  // Range checks only mean something while the partition is open and guarded
  assign chk_live = wreq.valid && wreq.in_eee && guard_q[NBWP_BIT_OPEN] &&
                    !guard_q[NBWP_BIT_DIS];

  chk_closed_blocks: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wreq.valid && wreq.in_eee && !guard_q[NBWP_BIT_OPEN]) |-> !wr_grant)
    else $error("closed partition granted write");

  chk_user_never: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wreq.valid && !wreq.in_eee) |-> wr_grant)
    else $error("user partition write blocked");

  chk_viol_sets: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wreq.valid && !wr_grant) |=> status_q[NBWP_ST_VIOL])
    else $error("violation flag not set");

  chk_range_top: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wreq.valid && wreq.in_eee && guard_q[NBWP_BIT_OPEN] && !guard_q[NBWP_BIT_DIS]
     && wreq.addr == NBWP_RANGE_END) |-> !wr_grant)
    else $error("range end not protected");

  chk_range_free: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wreq.valid && wreq.in_eee && guard_q[NBWP_BIT_OPEN] && guard_q[NBWP_BIT_DIS])
    |-> wr_grant)
    else $error("range disabled but write blocked");

  chk_open_noset: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!guard_q[NBWP_BIT_OPEN] && !nv_load.valid) |=> !guard_q[NBWP_BIT_OPEN])
    else $error("open bit set by write");

  chk_size_lock: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!guard_q[NBWP_BIT_DIS] && !nv_load.valid) |=> $stable(guard_q[2:0]))
    else $error("size changed while locked");

  chk_rnv_ro: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wr_guard && !nv_load.valid) |=> $stable(guard_q[6:4]))
    else $error("reserved bits written");

  chk_dbe_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (nv_load.valid && nv_load.dbe) |=> guard_q == NBWP_DBE_VALUE)
    else $error("double-bit load not protective");

  chk_scen_keep: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reject_scen |=> $stable(scen_q))
    else $error("rejected scenario taken");

  chk_scen_three: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (scen_q == 3'h3) |=> (scen_q == 3'h3))
    else $error("scenario 3 left");

  chk_irq_viol: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (status_q[NBWP_ST_VIOL] && viol_ie_q) |-> irq)
    else $error("violation interrupt missing");

  // Write path: both sides of the range's low edge, user writes and the grant gate
  chk_range_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (chk_live && wreq.addr == chk_lo) |-> !wr_grant)
    else $error("range low end not protected");

  chk_range_below: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (chk_live && wreq.addr == chk_lo - 23'h000001) |-> wr_grant)
    else $error("write below range blocked");

  chk_user_noflag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wreq.valid && !wreq.in_eee) |-> !blocked)
    else $error("user partition write flagged");

  chk_blocked_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
    blocked |-> !wr_grant)
    else $error("blocked write reached buffer");

  // Guard register: disable bit that only moves toward protection, and the nonvolatile load
  chk_dis_noset: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!guard_q[NBWP_BIT_DIS] && !nv_load.valid) |=> !guard_q[NBWP_BIT_DIS])
    else $error("disable bit set by write");

  chk_load_byte: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (nv_load.valid && !nv_load.dbe) |=> guard_q == $past(nv_load.byte_val))
    else $error("guard byte not loaded");

  // Scenario table, one row per check; the reset row allows anything
  chk_scen_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (scen_q == 3'h0) |=> (scen_q <= 3'h3))
    else $error("scenario 0 left illegally");

  chk_scen_one: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (scen_q == 3'h1) |=> (scen_q == 3'h1 || scen_q == 3'h3))
    else $error("scenario 1 left illegally");

  chk_scen_two: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (scen_q == 3'h2) |=> (scen_q == 3'h2 || scen_q == 3'h3))
    else $error("scenario 2 left illegally");

  chk_scen_four: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (scen_q == 3'h4) |=> (scen_q == 3'h3 || scen_q == 3'h4))
    else $error("scenario 4 left illegally");

  chk_scen_five: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (scen_q == 3'h5) |=> (scen_q >= 3'h2 && scen_q <= 3'h5))
    else $error("scenario 5 left illegally");

  chk_scen_six: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (scen_q == 3'h6) |=> (scen_q inside {3'h1, 3'h3, 3'h4, 3'h6}))
    else $error("scenario 6 left illegally");

  // Reject flag and interrupt masking
  chk_rej_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reject_scen |=> status_q[NBWP_ST_REJ])
    else $error("reject flag not set");

  chk_irq_mask: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (status_q[NBWP_ST_REJ] && mask_q[NBWP_ST_REJ]) |-> irq)
    else $error("reject interrupt missing");

  chk_irq_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (status_q == 2'h0) |-> !irq)
    else $error("interrupt without a flag");

  // Main scenarios
  cov_blocked: cover property (@(posedge clk_sys) disable iff (!reset_n) blocked);
  cov_rejected: cover property (@(posedge clk_sys) disable iff (!reset_n) reject_scen);
  cov_irq: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(irq));
  cov_dbe_load: cover property (@(posedge clk_sys) disable iff (!reset_n)
    nv_load.valid && nv_load.dbe);
  cov_range_hit: cover property (@(posedge clk_sys) disable iff (!reset_n)
    blocked && guard_q[NBWP_BIT_OPEN]);

endmodule

`default_nettype wire

// ==== verification/nbwp_bus_master.sv ====
`timescale 1ns/10ps
`default_nettype none

module nbwp_bus_master
  import nbwp_pkg::*;
(
  // Clock
  input  wire logic            clk_sys,
  // Command from bench
  input  wire logic            go,
  input  wire logic [22:0]     go_addr,
  input  wire logic            go_eee,
  // Write request toward guard
  output var nbwp_pkg::nbwp_wreq_t wreq
);
  import nbwp_pkg::*;

  initial wreq = '0;

  // One-cycle write; idle lines toggle so a stale address never looks live
  always @(posedge clk_sys) begin
    wreq.valid  <= go;
    wreq.addr   <= go ? go_addr : ~wreq.addr;
    wreq.in_eee <= go ? go_eee : ~wreq.in_eee;
    wreq.data   <= ~wreq.data;
  end
endmodule

`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import nbwp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic go = 1'b0;
  logic go_eee = 1'b0;
  logic [22:0] go_addr = '0;
  nbwp_wreq_t wreq;
  nbwp_nvload_t nv_load = '0;
  logic [3:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic wr_grant;
  logic irq;
  logic [2:0] pflash_scenario;
  logic [7:0] g_exp;
  logic seen;
  int miscompares = 0;
  int checks_done = 0;

  nbwp_bus_master u_nbwp_bus_master (.clk_sys(clk_sys), .go(go), .go_addr(go_addr),
    .go_eee(go_eee), .wreq(wreq));
  nbwp_guard u_nbwp_guard (.clk_sys(clk_sys), .reset_n(reset_n), .nv_load(nv_load),
    .wreq(wreq), .wr_grant(wr_grant), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .pflash_scenario(pflash_scenario));

  // 125 MHz system clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////
  function automatic logic scen_ok(input int f, input int t);
    case (f)
      0: return t <= 3;
      1: return t == 1 || t == 3;
      2: return t == 2 || t == 3;
      3: return t == 3;
      4: return t == 3 || t == 4;
      5: return t >= 2 && t <= 5;
      6: return t == 1 || t == 3 || t == 4 || t == 6;
      default: return 1'b1;
    endcase
  endfunction

  // Range is inclusive, ending at the top of the partition
  function automatic logic grant_exp(input logic [7:0] g, input logic [22:0] a,
                                     input logic e);
    logic [22:0] lo;
    lo = 23'h13FFFF - 23'h40 * ({20'h0, g[2:0]} + 23'h1) + 23'h1;
    return !(e && (!g[7] || (!g[3] && a >= lo && a <= 23'h13FFFF)));
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // stored byte keeps reserved bits erased
  task automatic do_reset(input logic [7:0] b, input logic dbe);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    nv_load <= '{1'b1, dbe, b};
    @(posedge clk_sys);
    nv_load.valid <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk("rdata", e, reg_rdata);
  endtask

  task automatic irq_is(input logic e);
    @(negedge clk_sys);
    chk("irq", {7'h0, e}, {7'h0, irq});
  endtask

  // Grant is combinational, so it is judged mid-cycle of the request
  task automatic req(input logic [22:0] a, input logic e);
    @(posedge clk_sys);
    go <= 1'b1;
    go_addr <= a;
    go_eee <= e;
    @(posedge clk_sys);
    go <= 1'b0;
    @(negedge clk_sys);
    chk("grant", {7'h0, grant_exp(g_exp, a, e)}, {7'h0, wr_grant});
    seen = seen | !grant_exp(g_exp, a, e);
  endtask

  // Hang guard
  initial begin
    repeat (50000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish();
  end

  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h2D65));
    seen = 1'b0;
    do_reset(8'h88, 1'b0);
    rd(4'h0, 8'h88);
    wr(4'h0, 8'hFD);
    rd(4'h0, 8'h8D);
    wr(4'h0, 8'h85);
    wr(4'h0, 8'h8B);
    rd(4'h0, 8'h85);
    g_exp = 8'h85;
    req(23'h13FE7F, 1'b1);
    req(23'h13FE80, 1'b1);
    req(23'h13FFFF, 1'b1);
    for (int i = 0; i < 40; i++) begin
      req(23'h13FD00 + 23'($urandom % 768), 1'($urandom));
    end
    rd(4'h2, {7'h0, seen});
    irq_is(1'b0);
    wr(4'h3, 8'h01);
    irq_is(1'b1);
    wr(4'h3, 8'h00);
    irq_is(1'b0);
    wr(4'h4, 8'h10);
    irq_is(1'b1);
    wr(4'h2, 8'h01);
    irq_is(1'b0);
    wr(4'h0, 8'h05);
    g_exp = 8'h05;
    rd(4'h0, 8'h05);
    req(23'h100000, 1'b0);
    rd(4'h2, 8'h00);
    req(23'h100000, 1'b1);
    rd(4'h2, 8'h01);
    irq_is(1'b1);
    do_reset(8'h88, 1'b1);
    rd(4'h0, 8'h7F);
    g_exp = 8'h7F;
    req(23'h120000 + 23'($urandom % 4096), 1'b1);
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        do_reset(8'h88, 1'b0);
        wr(4'h1, 8'(f));
        wr(4'h1, 8'(t));
        rd(4'h1, scen_ok(f, t) ? 8'(t) : 8'(f));
        chk("scen", scen_ok(f, t) ? 8'(t) : 8'(f), {5'h0, pflash_scenario});
        rd(4'h2, {6'h0, !scen_ok(f, t), 1'b0});
      end
    end
    // Rejected scenario raises its flag, masked into the interrupt
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h04);
    chk("scen", 8'h00, {5'h0, pflash_scenario});
    irq_is(1'b0);
    wr(4'h3, 8'h02);
    irq_is(1'b1);
    wr(4'h2, 8'h02);
    irq_is(1'b0);
    tally_and_finish();
  end
endmodule

`default_nettype wire
